// ### rtl/drtic_cfg.svh
`ifndef DRTIC_CFG_SVH
`define DRTIC_CFG_SVH

// Terminal function option codes
`define DRTIC_FC_BYPASS 5'h0E
`define DRTIC_FC_CLEAR 5'h12
`define DRTIC_FC_THERM 5'h13
// Thermistor sensing exists on terminal 5 only
`define DRTIC_THERM_MASK 7'h10
`define DRTIC_TRIP_THERM 8'h23
`define DRTIC_NO_TRIP 8'h00

// Times and derived cycle counts at 25 MHz
`define DRTIC_CLK_KHZ 25000
`define DRTIC_OFF_DLY_MS 1000
`define DRTIC_KEY_WIN_MS 3000
`define DRTIC_WAIT_UNIT_MS 100
`define DRTIC_BLINK_MS 250
`define DRTIC_OFF_DLY_CYC (`DRTIC_OFF_DLY_MS * `DRTIC_CLK_KHZ)
`define DRTIC_KEY_WIN_CYC (`DRTIC_KEY_WIN_MS * `DRTIC_CLK_KHZ)
`define DRTIC_WAIT_UNIT_CYC (`DRTIC_WAIT_UNIT_MS * `DRTIC_CLK_KHZ)
`define DRTIC_BLINK_CYC (`DRTIC_BLINK_MS * `DRTIC_CLK_KHZ)

`define DRTIC_N_TERM 7
`define DRTIC_N_LOUT 3
`define DRTIC_TMR_W 27
`define DRTIC_SEG_A 2'h1

`endif

// ### rtl/drtic_pkg.sv
`include "drtic_cfg.svh"
`default_nettype none

package drtic_pkg;

	typedef logic [4:0] drtic_fcode_t;
	typedef logic [7:0] drtic_tcode_t;

	typedef enum logic [2:0] {
		st_clear,
		st_normal,
		st_bypass,
		st_wait,
		st_match,
		st_trip
	} drtic_state_t;

	typedef struct packed {
		drtic_state_t                 st;
		logic                         fc_prev;
		logic [7:0]                   wait_units;
		logic                         trip;
		drtic_tcode_t                 tcode;
		logic [`DRTIC_N_LOUT-1:0]     lout;
		logic [`DRTIC_N_LOUT-1:0]     hold;
		logic                         motor_on;
		logic                         coast;
		logic                         match_req;
		logic                         zero_start;
		logic                         pwr_rst;
		logic                         key_ack;
		logic [1:0]                   seg;
	} drtic_top_st_t;

endpackage

`default_nettype wire

// ### rtl/drtic_tmr.sv
`timescale 1ns/100ps
`default_nettype none

module drtic_tmr #(
	parameter int         W       = 27,
	parameter logic [W-1:0] LOAD  = W'(1),
	parameter bit         RST_RUN = 1'b0
) (
	// Clock and reset
	input  wire logic     core_clk,
	input  wire logic     sys_rst,
	input  wire logic     clk_en,
	// Control
	input  wire logic     start,
	// Status
	output logic          busy,
	output logic          expire
);

	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;

	always_comb begin
		cnt_nxt = cnt_r;
		if (start) begin
			cnt_nxt = LOAD;
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - W'(1);
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_r <= RST_RUN ? LOAD : '0;
		end else if (clk_en) begin
			cnt_r <= cnt_nxt;
		end
	end

	assign busy   = (cnt_r != '0);
	// Independent of start, so a caller reloading on expire forms no loop
	assign expire = clk_en && (cnt_r == W'(1));

endmodule

`default_nettype wire

// ### rtl/drtic_fsel.sv
`timescale 1ns/100ps
`default_nettype none

module drtic_fsel #(
	parameter int                      N         = 7,
	parameter drtic_pkg::drtic_fcode_t CODE      = 5'h00,
	parameter bit           ALLOW_INV = 1'b1,
	parameter logic [N-1:0] MASK      = '1
) (
	// Terminals
	input  wire logic [N-1:0]      term_in,
	input  wire logic [N-1:0]      term_inv,
	input  wire logic [N-1:0][4:0] term_func,
	// Result
	output logic                   active,
	output logic                   assigned,
	output logic                   inv_set
);

	import drtic_pkg::*;

	always_comb begin
		active   = 1'b0;
		assigned = 1'b0;
		inv_set  = 1'b0;
		for (int i = 0; i < N; i++) begin
			if (MASK[i] && term_func[i] == CODE) begin
				assigned = 1'b1;
				inv_set  = inv_set | term_inv[i];
				active   = active | (term_in[i] ^ (ALLOW_INV & term_inv[i]));
			end
		end
	end

endmodule

`default_nettype wire

// ### rtl/drtic_top.sv
// Operation
// RULE1 - Bypass switch function may sit on any of seven inputs by option code.
// RULE2 - Bypass release with run: wait restart time, match frequency, accelerate.
// RULE3 - Low speed or fast voltage decay: start from 0 Hz instead.
// RULE4 - Fault-clear pulse performs reset, cancelling any trip.
// RULE5 - Fault-clear held: motor off, trip cleared, powerup reset applied.
// RULE6 - After alarm reset motor restarts at once if run still active.
// RULE7 - Alternating display while fault-clear held; normal display after release.
// RULE8 - Keypad stop/reset counts as reset only while an alarm exists.
// RULE9 - Fault-clear input is normally open only; inversion not honoured.
// RULE10 - Power-on runs same sequence as a fault-clear pulse.
// RULE11 - With remote operator, own stop/reset key works briefly after powerup.
// RULE12 - Fault-clear during running lets the motor coast.
// RULE13 - Without off delays, motor and logic outputs drop together at once.
// RULE14 - Delayed logic outputs stay on about one second after fault-clear.
// RULE15 - Thermistor sensing only on input terminal 5.
// RULE16 - Over-temperature trips, stops motor, reports thermistor trip code.
// RULE17 - Open thermistor circuit also trips and stops the motor.
// RULE18 - Keypad stop/reset clears thermistor trip once cooled.
// RULE19 - Any trip stays latched until fault-clear, keypad or power-on reset.
`timescale 1ns/100ps
`default_nettype none

`include "drtic_cfg.svh"

module drtic_top #(
	parameter int N_TERM        = `DRTIC_N_TERM,
	parameter int N_LOUT        = `DRTIC_N_LOUT,
	parameter int OFF_DLY_CYC   = `DRTIC_OFF_DLY_CYC,
	parameter int KEY_WIN_CYC   = `DRTIC_KEY_WIN_CYC,
	parameter int WAIT_UNIT_CYC = `DRTIC_WAIT_UNIT_CYC,
	parameter int BLINK_CYC     = `DRTIC_BLINK_CYC
) (
	// Clock, reset, enable
	input  wire logic                   core_clk,
	input  wire logic                   sys_rst,
	input  wire logic                   clk_en,
	// Intelligent input terminals
	input  wire logic [N_TERM-1:0]      term_in,
	input  wire logic [N_TERM-1:0]      term_inv,
	input  wire logic [N_TERM-1:0][4:0] term_func,
	// Drive state and settings
	input  wire logic                   run_cmd,
	input  wire logic [7:0]             restart_wait_time,
	input  wire logic                   speed_below_half,
	input  wire logic                   fast_decay,
	input  wire logic                   freq_match_done,
	// Thermistor and other trips
	input  wire logic                   motor_overtemp_sense,
	input  wire logic                   therm_open,
	input  wire logic                   ext_trip,
	input  wire drtic_pkg::drtic_tcode_t ext_trip_code,
	// Keypad
	input  wire logic                   key_stop_reset,
	input  wire logic                   remote_op_attached,
	// Logic outputs
	input  wire logic [N_LOUT-1:0]      logic_out_req,
	input  wire logic [N_LOUT-1:0]      output_off_delay,
	output logic [N_LOUT-1:0]           logic_out,
	// Motor control
	output logic                        motor_out_en,
	output logic                        motor_coast,
	output logic                        freq_match_req,
	output logic                        zero_hz_start,
	output logic                        powerup_reset,
	// Status and display
	output logic                        trip_active,
	output drtic_pkg::drtic_tcode_t     thermistor_trip_code,
	output logic                        display_alt,
	output logic [1:0]                  display_seg,
	output logic                        keypad_reset_ack,
	output logic                        fc_polarity_err
);

	import drtic_pkg::*;

	drtic_top_st_t r;
	drtic_top_st_t n;

	logic byp;
	logic byp_assigned;
	logic fc;
	logic fc_assigned;
	logic fc_inv;
	logic therm_en;
	logic therm_in_unused;
	logic therm_inv_unused;
	logic trip_req;
	drtic_tcode_t trip_code_req;
	logic key_win_busy;
	logic key_ok;
	logic off_start;
	logic off_busy;
	logic unit_start;
	logic unit_exp;
	logic blink_busy;
	logic blink_start;
	logic blink_exp;

	// Mains-bypass switch on any input [RULE1]
	drtic_fsel #(
		.N         (N_TERM),
		.CODE      (`DRTIC_FC_BYPASS),
		.ALLOW_INV (1'b1)
	) u_sel_byp (
		.term_in   (term_in),
		.term_inv  (term_inv),
		.term_func (term_func),
		.active    (byp),
		.assigned  (byp_assigned),
		.inv_set   ()
	);

	// Fault-clear ignores inversion setting [RULE9]
	drtic_fsel #(
		.N         (N_TERM),
		.CODE      (`DRTIC_FC_CLEAR),
		.ALLOW_INV (1'b0)
	) u_sel_fc (
		.term_in   (term_in),
		.term_inv  (term_inv),
		.term_func (term_func),
		.active    (fc),
		.assigned  (fc_assigned),
		.inv_set   (fc_inv)
	);

	// Thermistor only on terminal 5 [RULE15]
	drtic_fsel #(
		.N         (N_TERM),
		.CODE      (`DRTIC_FC_THERM),
		.ALLOW_INV (1'b0),
		.MASK      (N_TERM'(`DRTIC_THERM_MASK))
	) u_sel_therm (
		.term_in   (term_in),
		.term_inv  (term_inv),
		.term_func (term_func),
		.active    (therm_in_unused),
		.assigned  (therm_en),
		.inv_set   (therm_inv_unused)
	);

	// Keypad window runs from power-on [RULE11]
	drtic_tmr #(
		.W       (`DRTIC_TMR_W),
		.LOAD    (`DRTIC_TMR_W'(KEY_WIN_CYC)),
		.RST_RUN (1'b1)
	) u_key_win (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.start    (1'b0),
		.busy     (key_win_busy),
		.expire   ()
	);

	// One second hold of delayed outputs [RULE14]
	drtic_tmr #(
		.W    (`DRTIC_TMR_W),
		.LOAD (`DRTIC_TMR_W'(OFF_DLY_CYC))
	) u_off_dly (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.start    (off_start),
		.busy     (off_busy),
		.expire   ()
	);

	// Restart wait unit tick [RULE2]
	drtic_tmr #(
		.W    (`DRTIC_TMR_W),
		.LOAD (`DRTIC_TMR_W'(WAIT_UNIT_CYC))
	) u_wait_unit (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.start    (unit_start),
		.busy     (),
		.expire   (unit_exp)
	);

	// Segment alternation period [RULE7]
	drtic_tmr #(
		.W    (`DRTIC_TMR_W),
		.LOAD (`DRTIC_TMR_W'(BLINK_CYC))
	) u_blink (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.start    (blink_start),
		.busy     (blink_busy),
		.expire   (blink_exp)
	);

	// Trip sources; open circuit and over-temperature both trip
	always_comb begin
		trip_req      = 1'b0;
		trip_code_req = `DRTIC_NO_TRIP;
		if (ext_trip) begin
			trip_req      = 1'b1;
			trip_code_req = ext_trip_code;
		end
		if (therm_en && (motor_overtemp_sense || therm_open)) begin // [RULE16] [RULE17]
			trip_req      = 1'b1;
			trip_code_req = `DRTIC_TRIP_THERM;
		end
	end

	// Key honoured only during alarm, and in window if remote attached
	assign key_ok = key_stop_reset && r.trip
		&& (!remote_op_attached || key_win_busy); // [RULE8] [RULE11] [RULE18]

	assign off_start   = fc && !r.fc_prev && (logic_out_req & output_off_delay) != '0;
	assign blink_start = fc && (!blink_busy || blink_exp);

	always_comb begin
		n            = r;
		unit_start   = 1'b0;
		n.fc_prev    = fc;
		n.pwr_rst    = 1'b0;
		n.zero_start = 1'b0;
		n.key_ack    = 1'b0;
		n.match_req  = 1'b0;
		case (r.st)
			st_clear: begin
				// Release ends the reset; power-on starts here too
				if (!fc) begin
					n.pwr_rst = 1'b1; // [RULE4] [RULE10]
					n.trip    = 1'b0;
					n.tcode   = `DRTIC_NO_TRIP;
					n.st      = st_normal;
				end
			end
			st_normal: begin
				if (byp) begin
					n.st = st_bypass;
				end
			end
			st_bypass: begin
				if (!byp) begin
					if (run_cmd) begin
						n.wait_units = restart_wait_time; // [RULE2]
						n.st         = st_wait;
						unit_start   = (restart_wait_time != 8'h00);
					end else begin
						n.st = st_normal;
					end
				end
			end
			st_wait: begin
				if (r.wait_units == 8'h00) begin
					n.st = st_match;
				end else if (unit_exp) begin
					n.wait_units = r.wait_units - 8'h01;
					unit_start   = (r.wait_units != 8'h01);
				end
			end
			st_match: begin
				if (speed_below_half || fast_decay) begin
					n.zero_start = 1'b1; // [RULE3]
					n.st         = st_normal;
				end else if (freq_match_done) begin
					n.st = st_normal; // [RULE2]
				end else begin
					n.match_req = 1'b1; // [RULE2]
				end
			end
			st_trip: begin
				if (key_ok) begin
					n.key_ack = 1'b1; // [RULE18]
					n.st      = st_clear;
				end
			end
			default: begin
				n.st = st_clear;
			end
		endcase

		// Latch a new trip; held until some reset [RULE19]
		if (trip_req && r.st != st_clear && n.st != st_clear) begin
			if (!r.trip) begin
				n.tcode = trip_code_req;
			end
			n.trip = 1'b1;
			n.st   = st_trip;
		end

		// Fault-clear held overrides state, trip, trip code and match request [RULE5]
		if (fc) begin
			n.st        = st_clear;
			n.trip      = 1'b0;
			n.tcode     = `DRTIC_NO_TRIP;
			n.match_req = 1'b0;
			unit_start  = 1'b0;
		end

		// Run resumes at once after any reset [RULE6]
		n.motor_on = (n.st == st_normal) && run_cmd;
		n.coast    = (n.st == st_clear) || (n.st == st_bypass)
			|| (n.st == st_wait) || (n.st == st_trip); // [RULE12]

		// Logic outputs under fault-clear
		if (fc && !r.fc_prev) begin
			n.hold = logic_out_req & output_off_delay;
			n.lout = logic_out_req & output_off_delay; // [RULE13] [RULE14]
		end else if (fc) begin
			n.lout = r.hold & {N_LOUT{off_busy}}; // [RULE14]
		end else begin
			n.hold = '0;
			n.lout = logic_out_req;
		end

		// Alternating segments while held, normal after [RULE7]
		if (!fc) begin
			n.seg = 2'h0;
		end else if (!r.fc_prev) begin
			n.seg = `DRTIC_SEG_A;
		end else if (blink_exp) begin
			n.seg = ~r.seg;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			r            <= '0;
			r.st         <= st_clear; // [RULE10]
			r.tcode      <= `DRTIC_NO_TRIP;
		end else if (clk_en) begin
			r <= n;
		end
	end

	assign motor_out_en         = r.motor_on;
	assign motor_coast          = r.coast;
	assign freq_match_req       = r.match_req;
	assign zero_hz_start        = r.zero_start;
	assign powerup_reset        = r.pwr_rst;
	assign trip_active          = r.trip;
	assign thermistor_trip_code = r.tcode;
	assign logic_out            = r.lout;
	assign display_alt          = r.seg != 2'h0;
	assign display_seg          = r.seg;
	assign keypad_reset_ack     = r.key_ack;
	assign fc_polarity_err      = fc_assigned && fc_inv; // [RULE9]

endmodule

`default_nettype wire

// ### sim/drtic_far.sv
`timescale 1ns/100ps
`default_nettype none

module drtic_far (
	// Clock
	input  wire logic       core_clk,
	// Frequency match handshake
	input  wire logic       freq_match_req,
	input  wire logic [3:0] lag,
	output logic            freq_match_done
);
	int cnt = 0;

	// Speed search answers after lag cycles, prompt or slow
	always @(posedge core_clk) begin
		freq_match_done <= 1'b0;
		if (!freq_match_req)
			cnt <= 0;
		else if (cnt == lag)
			freq_match_done <= 1'b1;
		else
			cnt <= cnt + 1;
	end
endmodule

`default_nettype wire

// ### sim/drtic_top_checker.sv
`timescale 1ns/100ps
`default_nettype none

`include "drtic_cfg.svh"

module drtic_chk #(
	parameter int N_TERM = 7,
	parameter int N_LOUT = 3
) (
	// Clock and inputs
	input  wire logic                   core_clk,
	input  wire logic                   sys_rst,
	input  wire logic                   clk_en,
	input  wire logic [N_TERM-1:0]      term_in,
	input  wire logic [N_TERM-1:0][4:0] term_func,
	input  wire logic                   run_cmd,
	input  wire logic                   motor_overtemp_sense,
	input  wire logic                   therm_open,
	input  wire logic                   key_stop_reset,
	input  wire logic [N_LOUT-1:0]      output_off_delay,
	// Outputs
	input  wire logic [N_LOUT-1:0]      logic_out,
	input  wire logic                   motor_out_en,
	input  wire logic                   motor_coast,
	input  wire logic                   powerup_reset,
	input  wire logic                   trip_active,
	input  wire drtic_pkg::drtic_tcode_t thermistor_trip_code,
	input  wire logic                   display_alt,
	input  wire logic [1:0]             display_seg,
	input  wire logic                   keypad_reset_ack
);
	import drtic_pkg::*;

	logic fc;
	logic hot;

	always_comb begin
		fc = 1'b0;
		for (int i = 0; i < N_TERM; i++)
			fc |= term_in[i] && term_func[i] == `DRTIC_FC_CLEAR;
	end
	assign hot = term_func[4] == `DRTIC_FC_THERM && motor_overtemp_sense;

	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	clear_drive_off_a: assert property (clk_en && fc |=> !motor_out_en && motor_coast && !trip_active)
		else $error("drive not released under clear");
	clear_display_a: assert property (clk_en && fc |=> display_alt)
		else $error("display not alternating");
	clear_release_a: assert property (clk_en && $fell(fc) |=> powerup_reset && display_seg == 2'h0)
		else $error("no reset on clear release");
	hot_trip_a: assert property ((clk_en && hot && !fc) [*4] |=> trip_active && thermistor_trip_code == `DRTIC_TRIP_THERM && !motor_out_en)
		else $error("over temperature missed");
	trip_latch_a: assert property (clk_en && trip_active && !fc && !keypad_reset_ack |=> trip_active)
		else $error("trip dropped");
	key_no_alarm_a: assert property (clk_en && key_stop_reset && !trip_active |=> !keypad_reset_ack)
		else $error("key reset without alarm");
	key_reset_a: assert property (clk_en && keypad_reset_ack && !fc |=> powerup_reset)
		else $error("key reset not applied");
	run_restart_a: assert property (clk_en && powerup_reset && run_cmd && !fc && !hot && !therm_open |=> motor_out_en)
		else $error("no restart after reset");
	plain_out_off_a: assert property (clk_en && fc |=> (logic_out & ~output_off_delay) == '0)
		else $error("undelayed output still on");
	delay_hold_a: assert property (clk_en && $rose(fc) && logic_out[0] && output_off_delay[0] |=> logic_out[0] [*8])
		else $error("delayed output dropped early");

	cover property (keypad_reset_ack ##1 powerup_reset);
	cover property (trip_active && thermistor_trip_code == `DRTIC_TRIP_THERM);
	cover property (display_alt && display_seg != 2'h0);
endmodule

`default_nettype wire

// ### sim/drive_reset_trip_input_control_test.sv
`timescale 1ns/100ps
`default_nettype none

`include "drtic_cfg.svh"

module drive_reset_trip_input_control_test;
	import drtic_pkg::*;

	logic              core_clk, sys_rst, clk_en, run_cmd, speed_below_half, fast_decay;
	logic              freq_match_done, motor_overtemp_sense, therm_open, ext_trip;
	logic              key_stop_reset, remote_op_attached, motor_out_en, motor_coast;
	logic              freq_match_req, zero_hz_start, powerup_reset, trip_active;
	logic              display_alt, keypad_reset_ack, fc_polarity_err;
	logic [6:0]        term_in, term_inv;
	logic [6:0][4:0]   term_func, tf;
	logic [7:0]        restart_wait_time;
	logic [2:0]        logic_out_req, output_off_delay, logic_out;
	logic [1:0]        display_seg, s;
	logic [3:0]        lag;
	logic [31:0]       seed = 32'hF597;
	logic [31:0]       r;
	drtic_tcode_t      ext_trip_code, thermistor_trip_code;
	logic [2:0]        q[$];
	int                err_total, samples_checked, cyc_n, n, w;

	drtic_top #(.OFF_DLY_CYC(20), .KEY_WIN_CYC(50), .WAIT_UNIT_CYC(5), .BLINK_CYC(4)) uut (
		.core_clk, .sys_rst, .clk_en, .term_in, .term_inv, .term_func, .run_cmd,
		.restart_wait_time, .speed_below_half, .fast_decay, .freq_match_done,
		.motor_overtemp_sense, .therm_open, .ext_trip, .ext_trip_code, .key_stop_reset,
		.remote_op_attached, .logic_out_req, .output_off_delay, .logic_out, .motor_out_en,
		.motor_coast, .freq_match_req, .zero_hz_start, .powerup_reset, .trip_active,
		.thermistor_trip_code, .display_alt, .display_seg, .keypad_reset_ack, .fc_polarity_err
	);

	drtic_far far (.core_clk, .freq_match_req, .lag, .freq_match_done);

	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	task give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task step(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask

	task put(input int i, input logic v);
		@(posedge core_clk);
		term_in[i] <= v;
	endtask

	task setf(input int i, input logic [4:0] c);
		tf[i] = c;
		@(posedge core_clk);
		term_func <= tf;
	endtask

	// Operator press held one cycle
	task key_hit();
		@(posedge core_clk);
		key_stop_reset <= 1'b1;
		@(posedge core_clk);
		key_stop_reset <= 1'b0;
		#1;
	endtask

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cyc_n++;
		if (cyc_n == 3000) begin
			err_total++;
			give_verdict();
		end
	end

	initial begin
		{sys_rst, clk_en, run_cmd} = 3'h7;
		{speed_below_half, fast_decay, motor_overtemp_sense, therm_open, ext_trip} = 5'h00;
		{key_stop_reset, remote_op_attached, ext_trip_code} = 10'h000;
		{term_in, term_inv, term_func, tf} = '0;
		{restart_wait_time, logic_out_req, output_off_delay, lag} = '0;
		repeat (12) @(posedge core_clk);
		sys_rst <= 1'b0;
		step(1);
		chk("pwr_rst", powerup_reset, 1);
		step(1);
		chk("motor_en", motor_out_en, 1);
		repeat (6) begin
			r = xs();
			@(posedge core_clk);
			logic_out_req <= r[2:0];
			q.push_back(r[2:0]);
			step(1);
			chk("lout", logic_out, q.pop_front());
		end
		// Enable low freezes outputs
		@(posedge core_clk);
		clk_en <= 1'b0;
		q.push_back(~r[2:0]);
		logic_out_req <= ~r[2:0];
		step(3);
		chk("frozen", logic_out, r[2:0]);
		@(posedge core_clk);
		clk_en <= 1'b1;
		step(1);
		chk("lout", logic_out, q.pop_front());
		$display("start test done");
		for (int i = 0; i < 7; i++) begin
			r = xs();
			w = r[1:0] + 1;
			lag = 4'(i);
			setf(i, `DRTIC_FC_BYPASS);
			restart_wait_time <= 8'(w);
			speed_below_half <= i % 3 == 1;
			fast_decay <= i % 3 == 2;
			put(i, 1);
			step(2);
			chk("coast", motor_coast, 1);
			put(i, 0);
			n = 0;
			while (!zero_hz_start && !freq_match_req && n < 99) begin
				step(1);
				n++;
			end
			chk("wait", n >= w * 5 && n <= w * 5 + 4, 1);
			chk("zero_start", zero_hz_start, i % 3 != 0);
			chk("match_req", freq_match_req, i % 3 == 0);
			while (!motor_out_en && n < 199) begin
				step(1);
				n++;
			end
			chk("motor_en", motor_out_en, 1);
			setf(i, 5'h00);
		end
		// Release without run: straight back to normal, no wait
		setf(3, `DRTIC_FC_BYPASS);
		run_cmd <= 1'b0;
		put(3, 1);
		put(3, 0);
		step(2);
		chk("motor_en", motor_out_en, 0);
		chk("coast", motor_coast, 0);
		setf(3, 5'h00);
		run_cmd <= 1'b1;
		$display("bypass test done");
		setf(0, `DRTIC_FC_CLEAR);
		term_inv <= 7'h01;
		logic_out_req <= 3'h7;
		output_off_delay <= 3'h1;
		step(2);
		chk("pol_err", fc_polarity_err, 1);
		put(0, 1);
		step(1);
		chk("motor_en", motor_out_en, 0);
		chk("coast", motor_coast, 1);
		chk("lout", logic_out, 3'h1);
		chk("alt", display_alt, 1);
		s = display_seg;
		step(4);
		chk("seg", display_seg, s ^ 2'h3);
		chk("lout", logic_out, 3'h1);
		step(20);
		chk("lout", logic_out, 3'h0);
		put(0, 0);
		step(1);
		chk("pwr_rst", powerup_reset, 1);
		chk("seg", display_seg, 2'h0);
		step(1);
		chk("motor_en", motor_out_en, 1);
		$display("clear test done");
		setf(2, `DRTIC_FC_THERM);
		motor_overtemp_sense <= 1'b1;
		step(4);
		chk("trip", trip_active, 0);
		setf(2, 5'h00);
		setf(4, `DRTIC_FC_THERM);
		step(2);
		chk("trip", trip_active, 1);
		chk("code", thermistor_trip_code, `DRTIC_TRIP_THERM);
		chk("motor_en", motor_out_en, 0);
		@(posedge core_clk);
		motor_overtemp_sense <= 1'b0;
		step(5);
		chk("trip", trip_active, 1);
		key_hit();
		chk("ack", keypad_reset_ack, 1);
		step(1);
		chk("trip", trip_active, 0);
		step(1);
		chk("motor_en", motor_out_en, 1);
		key_hit();
		chk("ack", keypad_reset_ack, 0);
		@(posedge core_clk);
		therm_open <= 1'b1;
		step(2);
		chk("trip", trip_active, 1);
		chk("motor_en", motor_out_en, 0);
		@(posedge core_clk);
		therm_open <= 1'b0;
		put(0, 1);
		step(1);
		chk("trip", trip_active, 0);
		put(0, 0);
		step(2);
		// Other trip source latches its own code
		@(posedge core_clk);
		ext_trip <= 1'b1;
		ext_trip_code <= 8'h5A;
		step(2);
		chk("code", thermistor_trip_code, 8'h5A);
		@(posedge core_clk);
		ext_trip <= 1'b0;
		key_hit();
		step(2);
		chk("trip", trip_active, 0);
		$display("thermistor test done");
		@(posedge core_clk);
		remote_op_attached <= 1'b1;
		motor_overtemp_sense <= 1'b1;
		step(2);
		@(posedge core_clk);
		motor_overtemp_sense <= 1'b0;
		key_hit();
		chk("ack", keypad_reset_ack, 0);
		@(posedge core_clk);
		sys_rst <= 1'b1;
		step(2);
		@(posedge core_clk);
		sys_rst <= 1'b0;
		step(1);
		chk("pwr_rst", powerup_reset, 1);
		@(posedge core_clk);
		motor_overtemp_sense <= 1'b1;
		step(2);
		@(posedge core_clk);
		motor_overtemp_sense <= 1'b0;
		key_hit();
		chk("ack", keypad_reset_ack, 1);
		step(3);
		$display("remote test done");
		give_verdict();
	end
endmodule

bind drtic_top drtic_chk #(.N_TERM(N_TERM), .N_LOUT(N_LOUT)) chk_i (
	.core_clk, .sys_rst, .clk_en, .term_in, .term_func, .run_cmd, .motor_overtemp_sense,
	.therm_open, .key_stop_reset, .output_off_delay, .logic_out, .motor_out_en, .motor_coast,
	.powerup_reset, .trip_active, .thermistor_trip_code, .display_alt, .display_seg,
	.keypad_reset_ack
);

`default_nettype wire
